// [core/converter_end.sv]
// Converter end: link and calibration state machines steered by the host.
`timescale 1ns/1ps
module converter_end (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  startup_if.device                              ctl,
  input  wire logic [startup_pkg::SAMPLE_W-1:0]  sample_in,
  output logic                                   overrange_flag,
  output logic [startup_pkg::CNT_W-1:0]          cal_done_count,
  output logic [startup_pkg::MODE_W-1:0]         active_mode
);

  typedef enum logic [3:0] {
    LINK_HALT = 4'b0001,
    LINK_CGS  = 4'b0010,
    LINK_ILA  = 4'b0100,
    LINK_DATA = 4'b1000
  } link_state_type;

  typedef enum logic [2:0] {
    CAL_HALT = 3'b001,
    CAL_IDLE = 3'b010,
    CAL_RUN  = 3'b100
  } cal_state_type;

  function automatic logic [startup_pkg::SAMPLE_W-2:0] magnitude(
    input logic [startup_pkg::SAMPLE_W-1:0] s);
    logic [startup_pkg::SAMPLE_W-1:0] n;
    n = s[startup_pkg::SAMPLE_W-1] ? (~s + 12'h001) : s;
    return n[startup_pkg::SAMPLE_W-2:0];
  endfunction

  link_state_type                     link_q;
  cal_state_type                      cal_q;
  logic                               srst;
  logic                               sync_req;
  logic                               trig_prev_q;
  logic                               trig_rise;
  logic [startup_pkg::KM1_W-1:0]      km1_q;
  logic                               sync_sel_q;
  logic                               bg_q;
  logic                               offset_q;
  logic [startup_pkg::KM1_W-1:0]      frame_q;
  logic [startup_pkg::CNT_W-1:0]      mf_q;
  logic [startup_pkg::CNT_W-1:0]      cal_cnt_q;
  logic [startup_pkg::SAMPLE_W-2:0]   mag;

  assign srst      = reset | ctl.soft_reset;
  assign sync_req  = sync_sel_q ? ~ctl.timestamp_sync_n : ~ctl.single_ended_sync_input_n;
  assign trig_rise = ctl.calibration_sw_trigger & ~trig_prev_q;
  assign mag       = magnitude(sample_in);

  // Link settings are taken only while the link is halted.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      active_mode <= startup_pkg::MODE_RESET;
      km1_q       <= startup_pkg::KM1_RESET;
      sync_sel_q  <= 1'b0;
    end else if (!ctl.link_enable) begin
      active_mode <= ctl.link_mode_select;
      km1_q       <= ctl.multiframe_len_minus_one;
      sync_sel_q  <= ctl.sync_sel;
    end
  end

  // Calibration settings are taken only while calibration is halted.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bg_q     <= 1'b0;
      offset_q <= 1'b0;
    end else if (!ctl.cal_enable) begin
      bg_q     <= ctl.cal_background;
      offset_q <= ctl.offset_cal_enable;
    end
  end

  // Link state machine follows the sync request from the receiver.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link_q  <= LINK_HALT;
      frame_q <= '0;
      mf_q    <= '0;
    end else if (!ctl.link_enable) begin
      link_q <= LINK_HALT;
    end else begin
      unique case (link_q)
        LINK_HALT: begin
          link_q <= LINK_CGS;
        end
        LINK_CGS: begin
          frame_q <= '0;
          mf_q    <= '0;
          if (!sync_req) begin
            link_q <= LINK_ILA;
          end
        end
        LINK_ILA: begin
          if (sync_req) begin
            link_q <= LINK_CGS;
          end else if (frame_q == km1_q) begin
            frame_q <= '0;
            mf_q    <= mf_q + 8'h01;
            if (mf_q == startup_pkg::ILA_MULTIFRAMES - 8'h01) begin
              link_q <= LINK_DATA;
            end
          end else begin
            frame_q <= frame_q + 8'h01;
          end
        end
        LINK_DATA: begin
          if (sync_req) begin
            link_q <= LINK_CGS;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctl.lane_status <= startup_pkg::LANE_OFF;
    end else begin
      unique case (link_q)
        LINK_HALT: ctl.lane_status <= startup_pkg::LANE_OFF;
        LINK_CGS:  ctl.lane_status <= startup_pkg::LANE_CGS;
        LINK_ILA:  ctl.lane_status <= startup_pkg::LANE_ILA;
        LINK_DATA: ctl.lane_status <= startup_pkg::LANE_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= ctl.calibration_sw_trigger;
    end
  end

  // Calibration state machine; background mode reruns on its own.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cal_q          <= CAL_HALT;
      cal_cnt_q      <= '0;
      cal_done_count <= '0;
    end else if (!ctl.cal_enable) begin
      cal_q <= CAL_HALT;
    end else begin
      unique case (cal_q)
        CAL_HALT: begin
          cal_q <= CAL_IDLE;
        end
        CAL_IDLE: begin
          if (trig_rise || bg_q) begin
            cal_q     <= CAL_RUN;
            cal_cnt_q <= startup_pkg::CAL_RUN_CYC +
                         (offset_q ? startup_pkg::OFFSET_CAL_CYC : 8'h00);
          end
        end
        CAL_RUN: begin
          if (cal_cnt_q == 8'h00) begin
            cal_q          <= CAL_IDLE;
            cal_done_count <= cal_done_count + 8'h01;
          end else begin
            cal_cnt_q <= cal_cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctl.cal_busy   <= 1'b0;
      overrange_flag <= 1'b0;
    end else begin
      ctl.cal_busy   <= (cal_q == CAL_RUN);
      overrange_flag <= ctl.overrange_enable &&
                        (mag[10:3] >= ctl.overrange_threshold);
    end
  end

endmodule

// [core/startup_host.sv]
// Host end: start-up sequencer plus the receiver's sync request.
//
// Behaviour
// - Start only once the device clock is stable.
// - Pulse soft reset, then wait 1 us.
// - Link enable low halts the link machine.
// - Calibration enable low halts calibration machine.
// - Program link mode while both machines halted.
// - Multiframe length field holds frames minus one.
// - Choose single-ended or timestamp sync source.
// - Set calibration mode and offset while halted.
// - Enable calibration before re-enabling the link.
// - Optionally set overrange before link restart.
// - Link enable high restarts the link machine.
// - Receiver asserts and releases the sync request.
// - Trigger low then high starts a calibration.
`timescale 1ns/1ps
module startup_host (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  startup_if.host                                ctl,
  input  wire logic                              start,
  input  wire logic                              clk_stable,
  input  wire logic [startup_pkg::MODE_W-1:0]    cfg_mode,
  input  wire logic [startup_pkg::KM1_W:0]       cfg_frames_per_mf,
  input  wire logic                              cfg_sync_sel,
  input  wire logic                              cfg_cal_background,
  input  wire logic                              cfg_offset_cal,
  input  wire logic                              cfg_ovr_enable,
  input  wire logic [startup_pkg::THR_W-1:0]     cfg_ovr_threshold,
  input  wire logic                              resync,
  output logic                                   busy,
  output logic                                   done,
  output logic                                   link_up
);

  typedef enum logic [12:0] {
    ST_IDLE      = 13'b0000000000001,
    ST_WAIT_CLK  = 13'b0000000000010,
    ST_RESET     = 13'b0000000000100,
    ST_RST_WAIT  = 13'b0000000001000,
    ST_HALT_LINK = 13'b0000000010000,
    ST_HALT_CAL  = 13'b0000000100000,
    ST_LINK_CFG  = 13'b0000001000000,
    ST_CAL_CFG   = 13'b0000010000000,
    ST_CAL_ON    = 13'b0000100000000,
    ST_OVR_CFG   = 13'b0001000000000,
    ST_LINK_ON   = 13'b0010000000000,
    ST_TRIG_LOW  = 13'b0100000000000,
    ST_TRIG_HIGH = 13'b1000000000000
  } seq_state_type;

  seq_state_type                   seq_q;
  logic [startup_pkg::CNT_W-1:0]   wait_q;
  logic [startup_pkg::CNT_W-1:0]   cgs_q;
  logic                            sync_n_q;

  // Sequencer waits for start, a stable clock and the reset delay, then walks the remaining steps one per cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seq_q  <= ST_IDLE;
      wait_q <= '0;
    end else begin
      unique case (seq_q)
        ST_IDLE: begin
          if (start) begin
            seq_q <= ST_WAIT_CLK;
          end
        end
        ST_WAIT_CLK: begin
          if (clk_stable) begin
            seq_q <= ST_RESET;
          end
        end
        ST_RESET: begin
          wait_q <= startup_pkg::WAIT_CYC - 8'h01;
          seq_q  <= ST_RST_WAIT;
        end
        ST_RST_WAIT: begin
          if (wait_q == 8'h00) begin
            seq_q <= ST_HALT_LINK;
          end else begin
            wait_q <= wait_q - 8'h01;
          end
        end
        ST_HALT_LINK: seq_q <= ST_HALT_CAL;
        ST_HALT_CAL:  seq_q <= ST_LINK_CFG;
        ST_LINK_CFG:  seq_q <= ST_CAL_CFG;
        ST_CAL_CFG:   seq_q <= ST_CAL_ON;
        ST_CAL_ON:    seq_q <= ST_OVR_CFG;
        ST_OVR_CFG:   seq_q <= ST_LINK_ON;
        ST_LINK_ON:   seq_q <= ST_TRIG_LOW;
        ST_TRIG_LOW:  seq_q <= ST_TRIG_HIGH;
        ST_TRIG_HIGH: seq_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl.soft_reset <= 1'b0;
    end else begin
      ctl.soft_reset <= (seq_q == ST_RESET);
    end
  end

  // Enables of the two device state machines.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl.link_enable <= 1'b0;
      ctl.cal_enable  <= 1'b0;
    end else begin
      if (seq_q == ST_HALT_LINK) begin
        ctl.link_enable <= 1'b0;
      end else if (seq_q == ST_LINK_ON) begin
        ctl.link_enable <= 1'b1;
      end
      if (seq_q == ST_HALT_CAL) begin
        ctl.cal_enable <= 1'b0;
      end else if (seq_q == ST_CAL_ON) begin
        ctl.cal_enable <= 1'b1;
      end
    end
  end

  // Link settings are written with both machines halted.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl.link_mode_select         <= startup_pkg::MODE_RESET;
      ctl.multiframe_len_minus_one <= startup_pkg::KM1_RESET;
      ctl.sync_sel                 <= 1'b0;
    end else if (seq_q == ST_LINK_CFG) begin
      ctl.link_mode_select         <= cfg_mode;
      ctl.multiframe_len_minus_one <= 8'(cfg_frames_per_mf - 9'h001);
      ctl.sync_sel                 <= cfg_sync_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl.cal_background    <= 1'b0;
      ctl.offset_cal_enable <= 1'b0;
    end else if (seq_q == ST_CAL_CFG) begin
      ctl.cal_background    <= cfg_cal_background;
      ctl.offset_cal_enable <= cfg_offset_cal;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl.overrange_enable    <= 1'b0;
      ctl.overrange_threshold <= startup_pkg::THR_RESET;
    end else if (seq_q == ST_OVR_CFG) begin
      ctl.overrange_enable    <= cfg_ovr_enable;
      ctl.overrange_threshold <= cfg_ovr_threshold;
    end
  end

  // Software trigger goes low, then high, to start a calibration.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl.calibration_sw_trigger <= 1'b0;
    end else if (seq_q == ST_TRIG_LOW) begin
      ctl.calibration_sw_trigger <= 1'b0;
    end else if (seq_q == ST_TRIG_HIGH) begin
      ctl.calibration_sw_trigger <= 1'b1;
    end
  end

  // Receiver holds sync low until the lanes show a steady CGS.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_n_q <= 1'b0;
      cgs_q    <= '0;
    end else if (!ctl.link_enable || resync) begin
      sync_n_q <= 1'b0;
      cgs_q    <= '0;
    end else if (!sync_n_q) begin
      if (ctl.lane_status != startup_pkg::LANE_CGS) begin
        cgs_q <= '0;
      end else if (cgs_q == startup_pkg::CGS_HOLD_CYC - 8'h01) begin
        sync_n_q <= 1'b1;
      end else begin
        cgs_q <= cgs_q + 8'h01;
      end
    end
  end

  // Only the selected sync pin carries the request; the other rests high.
  assign ctl.single_ended_sync_input_n = sync_n_q | ctl.sync_sel;
  assign ctl.timestamp_sync_n          = sync_n_q | ~ctl.sync_sel;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      link_up <= 1'b0;
    end else begin
      busy    <= (seq_q != ST_IDLE);
      done    <= (seq_q == ST_TRIG_HIGH);
      link_up <= (ctl.lane_status == startup_pkg::LANE_DATA);
    end
  end

endmodule

// [core/startup_if.sv]
// Control, sync and status wires between host and converter.
`timescale 1ns/1ps
interface startup_if;
  logic                                 soft_reset;
  logic                                 link_enable;
  logic                                 cal_enable;
  logic [startup_pkg::MODE_W-1:0]       link_mode_select;
  logic [startup_pkg::KM1_W-1:0]        multiframe_len_minus_one;
  logic                                 sync_sel;
  logic                                 cal_background;
  logic                                 offset_cal_enable;
  logic                                 overrange_enable;
  logic [startup_pkg::THR_W-1:0]        overrange_threshold;
  logic                                 calibration_sw_trigger;
  logic                                 single_ended_sync_input_n;
  logic                                 timestamp_sync_n;
  startup_pkg::lane_status_type         lane_status;
  logic                                 cal_busy;

  modport device (
    input  soft_reset, link_enable, cal_enable, link_mode_select,
           multiframe_len_minus_one, sync_sel, cal_background,
           offset_cal_enable, overrange_enable, overrange_threshold,
           calibration_sw_trigger, single_ended_sync_input_n, timestamp_sync_n,
    output lane_status, cal_busy
  );

  modport host (
    output soft_reset, link_enable, cal_enable, link_mode_select,
           multiframe_len_minus_one, sync_sel, cal_background,
           offset_cal_enable, overrange_enable, overrange_threshold,
           calibration_sw_trigger, single_ended_sync_input_n, timestamp_sync_n,
    input  lane_status, cal_busy
  );
endinterface

// [core/startup_pkg.sv]
// Shared constants and types for the converter start-up link.
package startup_pkg;

  localparam int unsigned CLK_PERIOD_NS        = 40;
  localparam int unsigned SOFT_RESET_WAIT_NS   = 1000;
  localparam int unsigned SOFT_RESET_WAIT_CYC  =
    (SOFT_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned MODE_W               = 5;
  localparam int unsigned KM1_W                = 8;
  localparam int unsigned THR_W                = 8;
  localparam int unsigned SAMPLE_W             = 12;
  localparam int unsigned CNT_W                = 8;

  localparam logic [CNT_W-1:0]  CAL_RUN_CYC      = 8'h40;
  localparam logic [CNT_W-1:0]  OFFSET_CAL_CYC   = 8'h20;
  localparam logic [CNT_W-1:0]  ILA_MULTIFRAMES  = 8'h04;
  localparam logic [CNT_W-1:0]  CGS_HOLD_CYC     = 8'h04;
  localparam logic [CNT_W-1:0]  WAIT_CYC         = 8'(SOFT_RESET_WAIT_CYC);

  localparam logic [MODE_W-1:0] MODE_RESET       = 5'h00;
  localparam logic [KM1_W-1:0]  KM1_RESET        = 8'h1f;
  localparam logic [THR_W-1:0]  THR_RESET        = 8'hff;

  typedef enum logic [1:0] {
    LANE_OFF  = 2'h0,
    LANE_CGS  = 2'h1,
    LANE_ILA  = 2'h2,
    LANE_DATA = 2'h3
  } lane_status_type;

endpackage

// [test/startup_sva.sv]
// Concurrent checks on the wires between host and converter.
`timescale 1ns/1ps
module startup_sva (
  input wire logic                             core_clk,
  input wire logic                             reset,
  input wire logic                             soft_reset,
  input wire logic                             link_enable,
  input wire logic                             cal_enable,
  input wire logic [startup_pkg::MODE_W-1:0]   link_mode_select,
  input wire logic                             calibration_sw_trigger,
  input wire logic                             single_ended_sync_input_n,
  input wire logic                             timestamp_sync_n,
  input wire startup_pkg::lane_status_type     lane_status,
  input wire logic                             cal_busy
);
  logic [5:0] since_rst_q;

  // Counts cycles since the last soft reset, saturating.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      since_rst_q <= 6'h3f;
    end else if (soft_reset) begin
      since_rst_q <= 6'h00;
    end else if (since_rst_q != 6'h3f) begin
      since_rst_q <= since_rst_q + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_halt_link;
    !link_enable |-> ##2 lane_status == startup_pkg::LANE_OFF;
  endproperty
  a_halt_link: assert property (p_halt_link) else $error("link not halted");

  property p_halt_cal;
    !cal_enable |-> ##2 !cal_busy;
  endproperty
  a_halt_cal: assert property (p_halt_cal) else $error("calibration not halted");

  property p_restart_link;
    $rose(link_enable) |-> ##[1:3] lane_status == startup_pkg::LANE_CGS;
  endproperty
  a_restart_link: assert property (p_restart_link) else $error("link did not restart");

  property p_ila_after_release;
    $rose(single_ended_sync_input_n && timestamp_sync_n) && link_enable |->
      ##[1:3] lane_status == startup_pkg::LANE_ILA;
  endproperty
  a_ila_after_release: assert property (p_ila_after_release) else $error("no ILA");

  property p_one_sync_source;
    single_ended_sync_input_n || timestamp_sync_n;
  endproperty
  a_one_sync_source: assert property (p_one_sync_source) else $error("two sync pins");

  property p_sync_while_halted;
    !link_enable ##1 !link_enable |-> !(single_ended_sync_input_n && timestamp_sync_n);
  endproperty
  a_sync_while_halted: assert property (p_sync_while_halted) else $error("sync free");

  property p_cal_start;
    $rose(calibration_sw_trigger) && cal_enable && !cal_busy |-> ##[1:3] cal_busy;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_cal_min_run;
    $rose(cal_busy) |-> cal_busy [*8];
  endproperty
  a_cal_min_run: assert property (p_cal_min_run) else $error("calibration too short");

  property p_rst_wait;
    $changed(link_mode_select) || $rose(cal_enable) |->
      since_rst_q >= 6'(startup_pkg::WAIT_CYC);
  endproperty
  a_rst_wait: assert property (p_rst_wait) else $error("configured too soon");

  property p_cal_before_link;
    $rose(link_enable) |-> cal_enable;
  endproperty
  a_cal_before_link: assert property (p_cal_before_link) else $error("link before cal");

  property p_soft_reset_clears;
    soft_reset |=> lane_status == startup_pkg::LANE_OFF && !cal_busy;
  endproperty
  a_soft_reset_clears: assert property (p_soft_reset_clears) else $error("not cleared");
endmodule

// [test/tb.sv]
// Self-checking bench for the host and converter start-up link.
`timescale 1ns/1ps
`define CHK(act, exp) \
  begin \
    tests_run++; \
    if ((act) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH at %0t: got %0h expected %0h", $time, act, exp); \
    end \
  end
module tb;
  logic                                core_clk;
  logic                                reset;
  logic                                start;
  logic                                clk_stable;
  logic [startup_pkg::MODE_W-1:0]      cfg_mode;
  logic [startup_pkg::KM1_W:0]         cfg_k;
  logic                                cfg_sel;
  logic                                cfg_off;
  logic                                cfg_ovr;
  logic                                cfg_bg;
  logic [startup_pkg::THR_W-1:0]       cfg_thr;
  logic                                resync;
  logic [startup_pkg::SAMPLE_W-1:0]    sample_in;
  logic                                busy;
  logic                                done;
  logic                                link_up;
  logic                                overrange_flag;
  logic [startup_pkg::CNT_W-1:0]       cal_done_count;
  logic [startup_pkg::MODE_W-1:0]      active_mode;
  int                                  mismatches = 0;
  int                                  tests_run = 0;
  int                                  sr_cnt = 0;
  int                                  n;

  startup_if bus ();
  converter_end converter_end_i (.core_clk(core_clk), .reset(reset), .ctl(bus),
    .sample_in(sample_in), .overrange_flag(overrange_flag),
    .cal_done_count(cal_done_count), .active_mode(active_mode));
  startup_host startup_host_i (.core_clk(core_clk), .reset(reset), .ctl(bus),
    .start(start), .clk_stable(clk_stable), .cfg_mode(cfg_mode), .cfg_frames_per_mf(cfg_k),
    .cfg_sync_sel(cfg_sel), .cfg_cal_background(cfg_bg), .cfg_offset_cal(cfg_off),
    .cfg_ovr_enable(cfg_ovr), .cfg_ovr_threshold(cfg_thr), .resync(resync),
    .busy(busy), .done(done), .link_up(link_up));
  startup_sva startup_sva_i (.core_clk(core_clk), .reset(reset),
    .soft_reset(bus.soft_reset), .link_enable(bus.link_enable),
    .cal_enable(bus.cal_enable), .link_mode_select(bus.link_mode_select),
    .calibration_sw_trigger(bus.calibration_sw_trigger),
    .single_ended_sync_input_n(bus.single_ended_sync_input_n),
    .timestamp_sync_n(bus.timestamp_sync_n), .lane_status(bus.lane_status),
    .cal_busy(bus.cal_busy));

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (bus.soft_reset === 1'b1) sr_cnt++;
  end

  task automatic tally_and_finish();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic launch(input logic [4:0] mode, input logic [8:0] k, input logic sel,
                        input logic off, input logic ovr, input logic bg,
                        input logic [7:0] thr);
    @(posedge core_clk);
    cfg_mode <= mode;
    cfg_k <= k;
    cfg_sel <= sel;
    cfg_off <= off;
    cfg_ovr <= ovr;
    cfg_bg <= bg;
    cfg_thr <= thr;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
  endtask

  task automatic wait_done(output int cyc);
    cyc = 0;
    while (done !== 1'b1 && cyc < 500) begin
      tick(1);
      cyc++;
    end
  endtask

  task automatic link_check(input int k);
    int ila;
    ila = 0;
    for (int i = 0; i < 800 && link_up !== 1'b1; i++) begin
      tick(1);
      if (bus.lane_status === startup_pkg::LANE_ILA) ila++;
    end
    `CHK(link_up, 1'b1)
    `CHK(ila, 4 * k)
    `CHK(bus.lane_status, startup_pkg::LANE_DATA)
  endtask

  task automatic cal_meas(output int len);
    len = 0;
    for (int i = 0; i < 20 && bus.cal_busy !== 1'b1; i++) tick(1);
    while (bus.cal_busy === 1'b1 && len < 300) begin
      tick(1);
      len++;
    end
  endtask

  task automatic ovr_check(input logic [11:0] s, input logic e);
    @(posedge core_clk);
    sample_in <= s;
    tick(3);
    `CHK(overrange_flag, e)
  endtask

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    start = 1'b0;
    clk_stable = 1'b0;
    cfg_mode = 5'h00;
    cfg_k = 9'h000;
    cfg_sel = 1'b0;
    cfg_off = 1'b0;
    cfg_ovr = 1'b0;
    cfg_bg = 1'b0;
    cfg_thr = 8'h10;
    resync = 1'b0;
    sample_in = 12'h000;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    `CHK(bus.multiframe_len_minus_one, startup_pkg::KM1_RESET)
    `CHK(bus.lane_status, startup_pkg::LANE_OFF)
    `CHK(bus.single_ended_sync_input_n, 1'b0)
    $display("test reset values finished");
    launch(5'h0a, 9'h014, 1'b0, 1'b0, 1'b1, 1'b0, 8'h10);
    tick(30);
    `CHK(sr_cnt, 0)
    `CHK(busy, 1'b1)
    @(posedge core_clk);
    clk_stable <= 1'b1;
    wait_done(n);
    `CHK(done, 1'b1)
    `CHK(n, 11 + int'(startup_pkg::WAIT_CYC))
    `CHK(sr_cnt, 1)
    `CHK(bus.multiframe_len_minus_one, 8'h13)
    `CHK(bus.link_mode_select, 5'h0a)
    `CHK(bus.sync_sel, 1'b0)
    fork
      link_check(20);
      cal_meas(n);
    join
    `CHK(n >= 64 && n < 96, 1'b1)
    tick(2);
    `CHK(cal_done_count, 8'h01)
    `CHK(active_mode, 5'h0a)
    ovr_check(12'h7f8, 1'b1);
    ovr_check(12'h808, 1'b1);
    ovr_check(12'h008, 1'b0);
    $display("test first bring-up finished");
    @(posedge core_clk);
    resync <= 1'b1;
    tick(6);
    `CHK(bus.single_ended_sync_input_n, 1'b0)
    `CHK(bus.lane_status, startup_pkg::LANE_CGS)
    `CHK(link_up, 1'b0)
    @(posedge core_clk);
    resync <= 1'b0;
    link_check(20);
    $display("test resync finished");
    launch(5'h13, 9'h001, 1'b1, 1'b1, 1'b0, 1'b0, 8'h10);
    tick(5);
    launch(5'h13, 9'h001, 1'b1, 1'b1, 1'b0, 1'b0, 8'h10);
    wait_done(n);
    `CHK(done, 1'b1)
    `CHK(sr_cnt, 2)
    fork
      link_check(1);
      cal_meas(n);
    join
    `CHK(n >= 96, 1'b1)
    tick(2);
    `CHK(cal_done_count, 8'h01)
    `CHK(active_mode, 5'h13)
    `CHK(bus.sync_sel, 1'b1)
    `CHK(bus.multiframe_len_minus_one, 8'h00)
    @(posedge core_clk);
    resync <= 1'b1;
    tick(6);
    `CHK(bus.timestamp_sync_n, 1'b0)
    `CHK(bus.single_ended_sync_input_n, 1'b1)
    `CHK(bus.lane_status, startup_pkg::LANE_CGS)
    @(posedge core_clk);
    resync <= 1'b0;
    link_check(1);
    ovr_check(12'h7f8, 1'b0);
    $display("test second bring-up finished");
    launch(5'h05, 9'h002, 1'b0, 1'b0, 1'b1, 1'b1, 8'h80);
    wait_done(n);
    `CHK(done, 1'b1)
    link_check(2);
    tick(200);
    `CHK(cal_done_count > 8'h01, 1'b1)
    `CHK(busy, 1'b0)
    ovr_check(12'h400, 1'b1);
    ovr_check(12'h3f8, 1'b0);
    $display("test background calibration finished");
    tally_and_finish();
  end

  initial begin
    repeat (6000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
